//--- hw/apsram_map.svh
// timing counts and pin-level constants for the async psram host port
`ifndef APSRAM_MAP_SVH
`define APSRAM_MAP_SVH
`define APSRAM_CLK_PS 5000
`define APSRAM_ADDR_W 18
`define APSRAM_DATA_W 16
// times in ns as printed
`define APSRAM_T_WC_NS 70
`define APSRAM_T_PWE_NS 55
`define APSRAM_T_SD_NS 25
`define APSRAM_T_RC_NS 70
`define APSRAM_T_ACE_NS 70
`define APSRAM_T_HZ_NS 25
// least times round up to whole cycles
`define APSRAM_CYC(ns) (((ns) * 1000 + `APSRAM_CLK_PS - 1) / `APSRAM_CLK_PS)
`define APSRAM_WP_CYC `APSRAM_CYC(`APSRAM_T_PWE_NS)
`define APSRAM_WC_CYC `APSRAM_CYC(`APSRAM_T_WC_NS)
`define APSRAM_SD_CYC `APSRAM_CYC(`APSRAM_T_SD_NS)
`define APSRAM_RD_CYC `APSRAM_CYC(`APSRAM_T_ACE_NS)
`define APSRAM_RC_CYC `APSRAM_CYC(`APSRAM_T_RC_NS)
`define APSRAM_HZ_CYC `APSRAM_CYC(`APSRAM_T_HZ_NS)
`define APSRAM_CNT_W 5
`endif

//--- hw/apsram_pkg.sv
// types for the async psram host port
package apsram_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_write,
    st_wrec,
    st_read,
    st_turn
  } apsram_state_type;
endpackage

//--- hw/apsram_sync.sv
// two-stage synchroniser for the 16 data pin inputs
`timescale 1ns/1ps
`default_nettype none
module apsram_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // async in, synced out
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
  } apsram_sync_type;
  apsram_sync_type q;
  apsram_sync_type next_q;
  // first stage is read only by the second
  always_comb begin
    next_q.s1 = din;
    next_q.s2 = q.s1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign dout = q.s2;
endmodule
`default_nettype wire

//--- hw/apsram_host.sv
// host controller driving a 256k x 16 async pseudo static ram
`timescale 1ns/1ps
`default_nettype none
`include "apsram_map.svh"
// Notes on behaviour
// - read needs selects active, output strobe low, write strobe high
// - write is overlap of write strobe, selects and a lane enable
// - data taken at the edge ending the write; host holds it there
// - host keeps write 55 ns, cycle 70 ns, data setup 25 ns
// - address stable within 10 ns of read cycle start
// - prefer select-controlled reads with address set before select; here address, select and output strobe launch on one edge
// - host never drives data while device outputs
module apsram_host (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [17:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [1:0] req_lane,
  // read answer
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  // memory pins
  output logic [17:0] mem_addr,
  output logic select_low_active_alt_n,
  output logic select_high_active,
  output logic out_strobe_n,
  output logic write_strobe_n,
  output logic upper_byte_lane_n,
  output logic lower_byte_lane_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe
);
  // minimum times as whole cycles of the one clock
  localparam logic [4:0] WP_CYC = 5'(`APSRAM_WP_CYC);
  localparam logic [4:0] WC_CYC = 5'(`APSRAM_WC_CYC);
  localparam logic [4:0] SD_CYC = 5'(`APSRAM_SD_CYC);
  localparam logic [4:0] RD_CYC = 5'(`APSRAM_RD_CYC);
  localparam logic [4:0] RC_CYC = 5'(`APSRAM_RC_CYC);
  localparam logic [4:0] HZ_CYC = 5'(`APSRAM_HZ_CYC);
  // sync stages plus one cycle of margin for the sample
  localparam logic [4:0] RS_CYC = 5'(`APSRAM_RD_CYC + 3);

  typedef struct packed {
    apsram_pkg::apsram_state_type st;
    logic [4:0] cnt;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic [1:0] lane;
    logic sel;
    logic oe;
    logic we;
    logic drive;
    logic rsp;
    logic [15:0] rdata;
    logic [4:0] wlow;
  } apsram_host_type;

  apsram_host_type q;
  apsram_host_type next_q;
  // data pins after the two-stage synchroniser
  logic [15:0] data_sync;

  apsram_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .din(data_in),
    .dout(data_sync)
  );

  // lane enable to per-bit mask, used for drive and capture
  function automatic logic [15:0] lane_mask(input logic [1:0] ln);
    lane_mask = {{8{ln[1]}}, {8{ln[0]}}};
  endfunction

  // one request at a time; each phase is held for a rounded-up count
  always_comb begin
    next_q = q;
    next_q.rsp = 1'b0;
    case (q.st)
      apsram_pkg::st_idle: begin
        if (req_valid && req_lane != 2'h0) begin
          // address and lanes launch with select and hold for the whole access
          next_q.addr = req_addr;
          next_q.wdata = req_wdata;
          next_q.lane = req_lane;
          next_q.sel = 1'b1;
          next_q.cnt = 5'h00;
          if (req_write) begin
            next_q.we = 1'b1;
            next_q.oe = 1'b0;
            next_q.drive = 1'b1;
            next_q.st = apsram_pkg::st_write;
          end else begin
            next_q.oe = 1'b1;
            next_q.st = apsram_pkg::st_read;
          end
        end
      end
      apsram_pkg::st_write: begin
        next_q.cnt = q.cnt + 5'h01;
        // write pulse, and data setup inside it, both counted
        if (q.cnt + 5'h01 >= WP_CYC && q.cnt + 5'h01 >= SD_CYC) begin
          next_q.we = 1'b0;
          next_q.sel = 1'b0;
          next_q.st = apsram_pkg::st_wrec;
        end
      end
      apsram_pkg::st_wrec: begin
        // data held one cycle past the ending edge, then released
        next_q.drive = 1'b0;
        next_q.cnt = q.cnt + 5'h01;
        if (q.cnt + 5'h01 >= WC_CYC) begin
          next_q.st = apsram_pkg::st_idle;
        end
      end
      apsram_pkg::st_read: begin
        next_q.cnt = q.cnt + 5'h01;
        if (q.cnt + 5'h01 >= RS_CYC && q.cnt + 5'h01 >= RC_CYC) begin
          next_q.rdata = data_sync & lane_mask(q.lane);
          next_q.rsp = 1'b1;
          next_q.oe = 1'b0;
          next_q.sel = 1'b0;
          next_q.cnt = 5'h00;
          next_q.st = apsram_pkg::st_turn;
        end
      end
      apsram_pkg::st_turn: begin
        // wait for the device to float before another access
        next_q.cnt = q.cnt + 5'h01;
        if (q.cnt + 5'h01 >= HZ_CYC) begin
          next_q.st = apsram_pkg::st_idle;
        end
      end
      default: next_q.st = apsram_pkg::st_idle;
    endcase
    // consecutive cycles with the write strobe low, kept apart from cnt for the pulse check
    if (!q.we) begin
      next_q.wlow = 5'h00;
    end else if (q.wlow != 5'h1F) begin
      next_q.wlow = q.wlow + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // pins: lanes off when idle so the device is in standby
  assign req_ready = (q.st == apsram_pkg::st_idle);
  assign rsp_valid = q.rsp;
  assign rsp_rdata = q.rdata;
  assign mem_addr = q.addr;
  assign select_low_active_alt_n = ~q.sel;
  assign select_high_active = q.sel;
  assign out_strobe_n = ~q.oe;
  assign write_strobe_n = ~q.we;
  assign upper_byte_lane_n = ~(q.sel & q.lane[1]);
  assign lower_byte_lane_n = ~(q.sel & q.lane[0]);
  assign data_out = q.wdata;
  assign data_oe = q.drive ? lane_mask(q.lane) : 16'h0000;

  // assertions
  no_contend_a: assert property (@(posedge clk) disable iff (!rstn)
    (data_oe != 16'h0000) |-> out_strobe_n) else $error("host drives while read strobe low");
  wr_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(write_strobe_n) |-> q.wlow >= WP_CYC) else $error("write pulse too short");
  rd_excl_a: assert property (@(posedge clk) disable iff (!rstn)
    !out_strobe_n |-> write_strobe_n && !select_low_active_alt_n) else $error("read strobe without select");
  wr_overlap_a: assert property (@(posedge clk) disable iff (!rstn)
    !write_strobe_n |-> !select_low_active_alt_n && select_high_active) else $error("write without select");
  data_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(write_strobe_n) |-> data_oe != 16'h0000) else $error("data released at write end");
  rd_time_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(out_strobe_n) |-> !out_strobe_n [*8]) else $error("read strobe too short");
  turn_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(out_strobe_n) |-> req_ready == 1'b0 [*5]) else $error("no turnaround");
  standby_a: assert property (@(posedge clk) disable iff (!rstn)
    select_low_active_alt_n |-> upper_byte_lane_n && lower_byte_lane_n) else $error("lanes on while deselected");
  rsp_a: assert property (@(posedge clk) disable iff (!rstn)
    rsp_valid |-> $past(!out_strobe_n)) else $error("answer without read");
  // address rides with select and stays put for the whole access
  addr_stable_a: assert property (@(posedge clk) disable iff (!rstn)
    !select_low_active_alt_n && !$past(select_low_active_alt_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  lane_on_a: assert property (@(posedge clk) disable iff (!rstn)
    !write_strobe_n |-> !(upper_byte_lane_n && lower_byte_lane_n)) else $error("write with no lane");
  data_setup_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(write_strobe_n) |-> $past(data_oe, 5) != 16'h0000) else $error("data setup too short");
  // rest of the write cycle: select stays off for the cycle count minus the pulse count
  wr_gap_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(select_low_active_alt_n) && $past(!write_strobe_n) |-> select_low_active_alt_n [*3])
    else $error("write cycle too short");
  rsp_turn_a: assert property (@(posedge clk) disable iff (!rstn)
    rsp_valid |-> out_strobe_n && select_low_active_alt_n) else $error("answer before release");

  // main scenarios
  cov_wr_c: cover property (@(posedge clk) disable iff (!rstn) $rose(write_strobe_n));
  cov_rd_c: cover property (@(posedge clk) disable iff (!rstn) rsp_valid);
  cov_byte_c: cover property (@(posedge clk) disable iff (!rstn) !write_strobe_n && upper_byte_lane_n);
  cov_rd_byte_c: cover property (@(posedge clk) disable iff (!rstn)
    !out_strobe_n && !upper_byte_lane_n && lower_byte_lane_n);
  cov_turn_c: cover property (@(posedge clk) disable iff (!rstn) $rose(req_ready));
endmodule
`default_nettype wire

//--- bench/apsram_mem_model.sv
// behavioural model of the 256k x 16 pseudo static ram on the far side
`timescale 1ns/1ps
`default_nettype none
module apsram_mem_model (
  // host pins
  input wire logic [17:0] addr,
  input wire logic sel_n,
  input wire logic sel,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic ub_n,
  input wire logic lb_n,
  input wire logic [15:0] din,
  // device drive
  output logic [15:0] dq,
  output logic [15:0] dq_oe
);
  logic [15:0] mem [0:262143];
  logic act;
  logic wr;
  logic [17:0] wa = 18'h00000;
  logic [15:0] wd = 16'h0000;
  logic [1:0] wl = 2'h0;
  // selected with a lane enabled, else standby and floating
  assign act = !sel_n && sel && !(ub_n && lb_n);
  assign wr = act && !we_n;
  // drive only the enabled lanes of a read; floats in writes
  always_comb begin
    dq_oe = 16'h0000;
    dq = mem[addr];
    if (act && we_n && !oe_n) begin
      dq_oe = {{8{!ub_n}}, {8{!lb_n}}};
    end
  end
  // track the overlap from the pins themselves, so a write end that moves
  // several pins in one step never captures a half-released lane set
  always @(*) begin
    if (!sel_n && sel && !we_n && !(ub_n && lb_n)) begin
      wa = addr;
      wd = din;
      wl = {!ub_n, !lb_n};
    end
  end
  // store on the end of the overlap; a disabled lane keeps its byte
  always @(negedge wr) begin
    if (wl[0]) mem[wa][7:0] = wd[7:0];
    if (wl[1]) mem[wa][15:8] = wd[15:8];
  end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the async psram host port
`timescale 1ns/1ps
`default_nettype none
`include "apsram_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0, req_ready, req_write = 1'b0, rsp_valid;
  logic [17:0] req_addr = 18'h00000, mem_addr;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, data_in, data_out, data_oe, dev_q, dev_oe, q;
  logic [15:0] last = 16'h0000;
  logic [1:0] req_lane = 2'h0;
  logic sel_n, sel, oe_n, we_n, ub_n, lb_n;
  int mismatches = 0, comparisons = 0, cycles = 0;
  always #2.5 clk = ~clk;
  // released lines show the inverse of the last level, not a held value
  assign data_in = (data_oe & data_out) | (~data_oe & dev_oe & dev_q) | (~data_oe & ~dev_oe & ~last);
  apsram_host DUT (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lane(req_lane),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .select_low_active_alt_n(sel_n),
    .select_high_active(sel), .out_strobe_n(oe_n), .write_strobe_n(we_n), .upper_byte_lane_n(ub_n),
    .lower_byte_lane_n(lb_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  apsram_mem_model MEM (.addr(mem_addr), .sel_n(sel_n), .sel(sel), .oe_n(oe_n), .we_n(we_n),
    .ub_n(ub_n), .lb_n(lb_n), .din(data_in), .dq(dev_q), .dq_oe(dev_oe));
  // bus fight watch at the falling edge, where both sides have settled
  always @(negedge clk) begin
    if (rstn) `CHK(data_oe & dev_oe, 16'h0000)
  end
  // floating-line history and hang limit
  always @(posedge clk) begin
    last <= data_in;
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one request; writes check pins and pulse length, reads check answer timing
  task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] l);
    int n;
    logic [15:0] m;
    n = 0;
    m = {{8{l[1]}}, {8{l[0]}}};
    @(negedge clk);
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_lane = l;
    req_valid = 1'b1;
    // ready is settled at the falling edge; the next rising edge takes the request
    while (req_ready !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    @(negedge clk);
    `CHK(mem_addr, a)
    if (w) begin
      `CHK({sel_n, sel, we_n}, 3'h2)
      `CHK({ub_n, lb_n}, ~l)
      `CHK(dev_oe, 16'h0000)
      // the pulse was already low at the falling edge one cycle before this check
      n = 1;
      while (we_n === 1'b0 && n < 40) begin
        n++;
        @(negedge clk);
      end
      `CHK(n, `APSRAM_WP_CYC)
      `CHK(data_oe & data_out, d & m)
    end else begin
      `CHK({sel_n, sel, oe_n, we_n}, 4'h5)
      // access count plus two synchroniser stages and the sampling cycle
      n = 1;
      while (rsp_valid !== 1'b1 && n < 40) begin
        n++;
        @(negedge clk);
      end
      `CHK(n, `APSRAM_RD_CYC + 3)
      q = rsp_rdata;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    `CHK({sel_n, sel, data_oe}, {2'h2, 16'h0000})
    // top word, then a lower-only write keeps the upper byte
    op(1'b1, 18'h3FFFF, 16'h1234, 2'h3);
    op(1'b1, 18'h3FFFF, 16'hABCD, 2'h1);
    op(1'b0, 18'h3FFFF, 16'h0000, 2'h3);
    `CHK(q, 16'h12CD)
    op(1'b0, 18'h3FFFF, 16'h0000, 2'h2);
    `CHK(q, 16'h1200)
    op(1'b0, 18'h3FFFF, 16'h0000, 2'h1);
    `CHK(q, 16'h00CD)
    // upper-only write at address zero, read straight after
    op(1'b1, 18'h00000, 16'h5AFF, 2'h3);
    op(1'b1, 18'h00000, 16'h9900, 2'h2);
    op(1'b0, 18'h00000, 16'h0000, 2'h3);
    `CHK(q, 16'h99FF)
    // no lane enabled: nothing is taken and the pins stay idle
    req_lane = 2'h0;
    req_valid = 1'b1;
    repeat (6) @(negedge clk);
    `CHK({req_ready, sel_n, we_n, oe_n}, 4'hF)
    req_valid = 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
